// *** tb_top.sv ***
// Self-checking bench for the time code hold-off and jam block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, tick, evalid, pend, rec, ffd, dash, noedit, irq;
  logic run = 1'b0;
  logic adv = 1'b0;
  logic tick_en = 1'b0;
  logic preroll = 1'b0;
  logic ce = 1'b1;
  logic [4:0] erate = 5'h1E;
  tc_holdoff_pkg::tc_value_type etc, gen;
  int failures = 0;
  int checks = 0;
  int n;
  always #12.5 mclk_i = ~mclk_i;
  timecode_holdoff_jam #(.TICK_CYCLES(4)) i_timecode_holdoff_jam (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .frame_tick_i(tick), .ext_valid_i(evalid),
    .ext_tc_i(etc), .ext_rate_i(erate), .preroll_set_i(preroll), .record_pending_o(pend),
    .recording_o(rec), .file_from_detect_o(ffd), .ext_dashes_o(dash), .gen_tc_o(gen),
    .no_editable_field_notice_o(noedit), .irq_o(irq));
  tc_source_model i_tc_source_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .run_i(run),
    .adv_i(adv), .tick_en_i(tick_en), .rate_i(erate), .frame_tick_o(tick),
    .ext_valid_o(evalid), .ext_tc_o(etc));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait; the limit keeps a dead output from hanging the run
  task automatic wait_sig(input logic use_rec, input logic v);
    n = 0;
    while (((use_rec ? rec : pend) !== v) && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 400) failures++;
  endtask
  task automatic wait_gen(input tc_holdoff_pkg::tc_value_type old);
    n = 0;
    while (gen === old && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 40) failures++;
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge mclk_i);
    failures++;
    stop_test;
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    apb(1'b0, tc_holdoff_pkg::APB_HOLDOFF, 32'h0);
    chk("holdoff_rst", 32'h14, rd);
    apb(1'b1, tc_holdoff_pkg::APB_HOLDOFF, 32'h60);
    apb(1'b0, tc_holdoff_pkg::APB_HOLDOFF, 32'h0);
    chk("holdoff_clip", 32'h50, rd);
    preroll <= 1'b1;
    apb(1'b1, tc_holdoff_pkg::APB_IRQ_EN, 32'h7);
    apb(1'b1, tc_holdoff_pkg::APB_HOLDOFF, 32'h5);
    apb(1'b1, tc_holdoff_pkg::APB_MODE, 32'h1E04);
    run <= 1'b1;
    adv <= 1'b1;
    tick_en <= 1'b1;
    wait_sig(1'b0, 1'b1);
    chk("pending", 32'h1, {31'h0, pend & ~rec});
    chk("irq_pend", 32'h1, {31'h0, irq});
    chk("file_start", 32'h1, {31'h0, ffd});
    wait_sig(1'b1, 1'b1);
    chk("holdoff_span", 32'h1, {31'h0, n >= 18 && n <= 26});
    adv <= 1'b0;
    wait_sig(1'b1, 1'b0);
    chk("rec_stop", 32'h1, {31'h0, n < 40});
    apb(1'b0, tc_holdoff_pkg::APB_STATUS, 32'h0);
    chk("rates", 32'h1E1E, {16'h0, 3'h0, rd[20:16], 3'h0, rd[12:8]});
    run <= 1'b0;
    apb(1'b1, tc_holdoff_pkg::APB_IRQ_CLR, 32'h7);
    apb(1'b0, tc_holdoff_pkg::APB_IRQ_STAT, 32'h0);
    chk("irq_clr", 32'h0, {29'h0, rd[2:0]});
    chk("irq_low", 32'h0, {31'h0, irq});
    chk("dashes", 32'h1, {31'h0, dash});
    apb(1'b0, tc_holdoff_pkg::APB_EXT, 32'h0);
    chk("ext_invalid", 32'h1, {31'h0, rd[22]});
    // Long hold-off, code lost mid-count
    apb(1'b1, tc_holdoff_pkg::APB_HOLDOFF, 32'h50);
    apb(1'b1, tc_holdoff_pkg::APB_IRQ_EN, 32'h0);
    run <= 1'b1;
    adv <= 1'b1;
    repeat (40) @(posedge mclk_i);
    chk("early_state", 32'h1, {30'h0, rec, pend});
    run <= 1'b0;
    repeat (4) @(posedge mclk_i);
    chk("cancel_state", 32'h0, {30'h0, rec, pend});
    apb(1'b0, tc_holdoff_pkg::APB_IRQ_STAT, 32'h0);
    chk("cancel_irq", 32'h1, {31'h0, rd[2]});
    chk("irq_mask", 32'h0, {31'h0, irq});
    apb(1'b1, tc_holdoff_pkg::APB_IRQ_CLR, 32'h7);
    apb(1'b1, tc_holdoff_pkg::APB_HOLDOFF, 32'h0);
    apb(1'b1, tc_holdoff_pkg::APB_MODE, 32'h1E01);
    run <= 1'b1;
    repeat (40) @(posedge mclk_i);
    chk("free_no_hold", 32'h0, {30'h0, rec, pend});
    apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h1);
    wait_gen(~etc);
    repeat (30) @(posedge mclk_i);
    chk("jam_ext", {10'h0, etc}, {10'h0, gen});
    // Enable low must hold the generator across frame ticks
    ce <= 1'b0;
    @(posedge mclk_i);
    rd = {10'h0, gen};
    repeat (20) @(posedge mclk_i);
    chk("ce_freeze", rd, {10'h0, gen});
    ce <= 1'b1;
    tick_en <= 1'b0;
    apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h2);
    @(posedge mclk_i);
    chk("jam_zero", 32'h0, {10'h0, gen});
    apb(1'b1, tc_holdoff_pkg::APB_PRESET, {10'h0, 5'h17, 6'h3B, 6'h3B, 5'h1D});
    apb(1'b1, tc_holdoff_pkg::APB_PRESET, {10'h0, 5'h18, 6'h00, 6'h00, 5'h00});
    apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h4);
    @(posedge mclk_i);
    chk("jam_preset", {10'h0, 5'h17, 6'h3B, 6'h3B, 5'h1D}, {10'h0, gen});
    apb(1'b1, tc_holdoff_pkg::APB_MODE, 32'h1E09);
    for (int i = 0; i < 2; i++) begin
      tick_en <= 1'b0;
      apb(1'b1, tc_holdoff_pkg::APB_PRESET, {10'h0, 5'h00, 6'(i * 9), 6'h3B, 5'h1D});
      apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h4);
      @(posedge mclk_i);
      tick_en <= 1'b1;
      wait_gen(gen);
      chk("drop_frame", {15'h0, 6'(i * 9 + 1), 6'h00, 5'(2 - 2 * i)}, {10'h0, gen});
    end
    apb(1'b1, tc_holdoff_pkg::APB_MODE, 32'h1E01);
    apb(1'b1, tc_holdoff_pkg::APB_PRESET, {10'h0, 5'h0C, 17'h0});
    apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h4);
    erate <= 5'h19;
    apb(1'b1, tc_holdoff_pkg::APB_CMD, 32'h1);
    n = 0;
    while (gen !== etc && n < 400) begin
      @(posedge mclk_i);
      n++;
    end
    chk("cross_jam", {10'h0, etc.seconds, 5'h00}, {10'h0, gen.seconds, gen.frames});
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, tc_holdoff_pkg::APB_MODE, 32'h1E01 | (i << 4));
      @(posedge mclk_i);
      chk("ubits_notice", {31'h0, i == 2 || i == 3}, {31'h0, noedit});
    end
    stop_test;
  end
endmodule
`default_nettype wire

// *** tc_holdoff_pkg.sv ***
// Package of constants and carrier types for the time code hold-off and jam block
// Overview of operation
// - External auto-record follows advancing incoming code
// - Hold-off programmable zero to eight seconds, tenths
// - Factory hold-off value is two seconds
// - Record pending raised on code detection
// - Record starts only after hold-off elapses
// - Hold-off applies only in auto-record modes
// - Pre-roll file start at detection, else expiry
// - Jam from incoming loads generator from input
// - Missing incoming code flagged invalid, show dashes
// - Cross-rate jam waits for second boundary
// - Jam to zero clears every generator field
// - Preset limited to valid code, jam loads it
// - Seven user-bit modes, flag no editable part
// - Drop-frame skips two frames non-tenth minutes
// - Jam view shows both rates, external first
package tc_holdoff_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int TENTH_MS = 100;
  localparam int TICK_CYC = CLK_HZ / 1000 * TENTH_MS;
  localparam logic [6:0] HOLDOFF_MAX = 7'h50;
  localparam logic [6:0] HOLDOFF_RST = 7'h14;
  localparam logic [4:0] RATE_RST = 5'h1E;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MINSEC_MAX = 6'h3B;
  localparam logic [4:0] FRAME_MAX = 5'h1D;
  localparam logic [2:0] UB_MODES = 3'h7;
  localparam logic [7:0] UB_NOEDIT_MASK = 8'h0C;
  localparam logic [11:0] APB_HOLDOFF = 12'h000;
  localparam logic [11:0] APB_MODE = 12'h004;
  localparam logic [11:0] APB_CMD = 12'h008;
  localparam logic [11:0] APB_PRESET = 12'h00C;
  localparam logic [11:0] APB_STATUS = 12'h010;
  localparam logic [11:0] APB_EXT = 12'h014;
  localparam logic [11:0] APB_GEN = 12'h018;
  localparam logic [11:0] APB_IRQ_STAT = 12'h01C;
  localparam logic [11:0] APB_IRQ_EN = 12'h020;
  localparam logic [11:0] APB_IRQ_CLR = 12'h024;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_FREE = 3'b001,
    MODE_EXT = 3'b010,
    MODE_EXT_CONT = 3'b011,
    MODE_AUTO = 3'b100,
    MODE_AUTO_CONT = 3'b101
  } tc_mode_type;

  typedef enum logic [1:0] {
    AR_IDLE = 2'b00,
    AR_PENDING = 2'b01,
    AR_RECORD = 2'b10
  } ar_state_type;

  typedef struct packed {
    logic [4:0] hours;
    logic [5:0] minutes;
    logic [5:0] seconds;
    logic [4:0] frames;
  } tc_value_type;
endpackage

// *** tc_source_model.sv ***
// Behavioural external time code source that steps frames at a fixed tick spacing
`timescale 1ns/1ps
`default_nettype none
module tc_source_model (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic adv_i,
  input wire logic tick_en_i,
  input wire logic [4:0] rate_i,
  output logic frame_tick_o,
  output logic ext_valid_o,
  output tc_holdoff_pkg::tc_value_type ext_tc_o
);
  logic [2:0] cnt_r;
  tc_holdoff_pkg::tc_value_type tc_r;
  assign frame_tick_o = tick_en_i && (cnt_r == 3'h7);
  assign ext_valid_o = run_i;
  // Released code shows the inverse so a stale value never passes as live
  assign ext_tc_o = run_i ? tc_r : ~tc_r;
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 3'h0;
      tc_r <= '0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      if (frame_tick_o && run_i && adv_i) begin
        tc_r.frames <= (tc_r.frames == rate_i - 5'h1) ? 5'h00 : tc_r.frames + 5'h01;
        if (tc_r.frames == rate_i - 5'h1) tc_r.seconds <= tc_r.seconds + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** timecode_holdoff_jam.sv ***
// Time code hold-off, auto-record and generator jam logic with APB registers
`timescale 1ns/1ps
`default_nettype none
module timecode_holdoff_jam #(
  parameter int TICK_CYCLES = tc_holdoff_pkg::TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic frame_tick_i,
  input wire logic ext_valid_i,
  input wire tc_holdoff_pkg::tc_value_type ext_tc_i,
  input wire logic [4:0] ext_rate_i,
  input wire logic preroll_set_i,
  output logic record_pending_o,
  output logic recording_o,
  output logic file_from_detect_o,
  output logic ext_dashes_o,
  output tc_holdoff_pkg::tc_value_type gen_tc_o,
  output logic no_editable_field_notice_o,
  output logic irq_o
);
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("TICK_CYCLES must be at least one");
  end

  logic [6:0] holdoff_r;
  tc_holdoff_pkg::tc_mode_type mode_r;
  logic drop_r;
  logic [2:0] ubmode_r;
  logic [4:0] rate_r;
  tc_holdoff_pkg::tc_value_type preset_r;
  tc_holdoff_pkg::tc_value_type gen_r;
  tc_holdoff_pkg::tc_value_type ext_prev_r;
  tc_holdoff_pkg::ar_state_type ar_r;
  logic [31:0] tick_cnt_r;
  logic [6:0] tenth_r;
  logic xjam_pend_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_en_r;
  logic ext_valid_d_r;

  wire wr = psel_i && penable_i && pwrite_i && ce_i;
  wire auto_mode = (mode_r == tc_holdoff_pkg::MODE_AUTO) ||
    (mode_r == tc_holdoff_pkg::MODE_AUTO_CONT);
  wire ext_adv = ext_valid_i && frame_tick_i && (ext_tc_i != ext_prev_r);
  wire cmd_wr = wr && (paddr_i == tc_holdoff_pkg::APB_CMD);
  wire jam_ext = cmd_wr && pwdata_i[0];
  wire jam_zero = cmd_wr && pwdata_i[1];
  wire jam_preset = cmd_wr && pwdata_i[2];
  wire rates_differ = ext_rate_i != rate_r;
  wire ext_sec_edge = ext_valid_i && (ext_tc_i.frames == 5'h00);
  wire tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
  wire expired = (tenth_r >= holdoff_r);
  wire pend_ev = ext_valid_i && !ext_valid_d_r;
  wire rec_ev = (ar_r == tc_holdoff_pkg::AR_PENDING) && expired;
  wire cancel_ev = (ar_r == tc_holdoff_pkg::AR_PENDING) && !ext_valid_i;

  function automatic logic preset_ok(input tc_holdoff_pkg::tc_value_type v);
    preset_ok = (v.hours <= tc_holdoff_pkg::HOUR_MAX) &&
      (v.minutes <= tc_holdoff_pkg::MINSEC_MAX) &&
      (v.seconds <= tc_holdoff_pkg::MINSEC_MAX) &&
      (v.frames <= tc_holdoff_pkg::FRAME_MAX);
  endfunction

  function automatic tc_holdoff_pkg::tc_value_type tc_inc(
      input tc_holdoff_pkg::tc_value_type v, input logic drop);
    tc_holdoff_pkg::tc_value_type n;
    n = v;
    if (v.frames != tc_holdoff_pkg::FRAME_MAX) begin
      n.frames = v.frames + 5'h01;
    end else begin
      n.frames = 5'h00;
      if (v.seconds != tc_holdoff_pkg::MINSEC_MAX) begin
        n.seconds = v.seconds + 6'h01;
      end else begin
        n.seconds = 6'h00;
        if (v.minutes != tc_holdoff_pkg::MINSEC_MAX) begin
          n.minutes = v.minutes + 6'h01;
        end else begin
          n.minutes = 6'h00;
          n.hours = (v.hours == tc_holdoff_pkg::HOUR_MAX) ? 5'h00 : v.hours + 5'h01;
        end
        // Frames 0 and 1 skipped except every tenth minute
        if (drop && ((n.minutes % 6'h0A) != 6'h00)) begin
          n.frames = 5'h02;
        end
      end
    end
    tc_inc = n;
  endfunction

  // Settings registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      holdoff_r <= tc_holdoff_pkg::HOLDOFF_RST;
      mode_r <= tc_holdoff_pkg::MODE_OFF;
      drop_r <= 1'b0;
      ubmode_r <= 3'h0;
      rate_r <= tc_holdoff_pkg::RATE_RST;
      preset_r <= '0;
      irq_en_r <= 3'h0;
    end else if (wr) begin
      case (paddr_i)
        tc_holdoff_pkg::APB_HOLDOFF: begin
          // Out-of-range values are clipped rather than refused
          holdoff_r <= (pwdata_i[6:0] > tc_holdoff_pkg::HOLDOFF_MAX) ?
            tc_holdoff_pkg::HOLDOFF_MAX : pwdata_i[6:0];
        end
        tc_holdoff_pkg::APB_MODE: begin
          mode_r <= tc_holdoff_pkg::tc_mode_type'(pwdata_i[2:0]);
          drop_r <= pwdata_i[3];
          if (pwdata_i[6:4] < tc_holdoff_pkg::UB_MODES) begin
            ubmode_r <= pwdata_i[6:4];
          end
          rate_r <= pwdata_i[12:8];
        end
        tc_holdoff_pkg::APB_PRESET: begin
          if (preset_ok(pwdata_i[21:0])) begin
            preset_r <= pwdata_i[21:0];
          end
        end
        tc_holdoff_pkg::APB_IRQ_EN: begin
          irq_en_r <= pwdata_i[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Previous incoming code and validity for advance and detect
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ext_prev_r <= '0;
      ext_valid_d_r <= 1'b0;
    end else if (ce_i) begin
      ext_valid_d_r <= ext_valid_i;
      if (frame_tick_i) begin
        ext_prev_r <= ext_tc_i;
      end
    end
  end

  // Tenth-second tick and hold-off count
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_r <= 32'h0;
      tenth_r <= 7'h00;
    end else if (ce_i) begin
      if (ar_r != tc_holdoff_pkg::AR_PENDING) begin
        tick_cnt_r <= 32'h0;
        tenth_r <= 7'h00;
      end else if (tick) begin
        tick_cnt_r <= 32'h0;
        if (!expired) begin
          tenth_r <= tenth_r + 7'h01;
        end
      end else begin
        tick_cnt_r <= tick_cnt_r + 32'h1;
      end
    end
  end

  // Auto-record sequencer
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ar_r <= tc_holdoff_pkg::AR_IDLE;
    end else if (ce_i) begin
      case (ar_r)
        tc_holdoff_pkg::AR_IDLE: begin
          if (auto_mode && ext_valid_i) begin
            ar_r <= tc_holdoff_pkg::AR_PENDING;
          end
        end
        tc_holdoff_pkg::AR_PENDING: begin
          if (!auto_mode || !ext_valid_i) begin
            ar_r <= tc_holdoff_pkg::AR_IDLE;
          end else if (expired) begin
            ar_r <= tc_holdoff_pkg::AR_RECORD;
          end
        end
        tc_holdoff_pkg::AR_RECORD: begin
          // Stationary or lost code stops the take
          if (!auto_mode || !ext_valid_i || (frame_tick_i && !ext_adv)) begin
            ar_r <= tc_holdoff_pkg::AR_IDLE;
          end
        end
        default: begin
          ar_r <= tc_holdoff_pkg::AR_IDLE;
        end
      endcase
    end
  end

  // Generator: jams have priority over running
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gen_r <= '0;
      xjam_pend_r <= 1'b0;
    end else if (ce_i) begin
      if (jam_zero) begin
        gen_r <= '0;
        xjam_pend_r <= 1'b0;
      end else if (jam_preset) begin
        gen_r <= preset_r;
        xjam_pend_r <= 1'b0;
      end else if ((jam_ext || xjam_pend_r) && ext_valid_i) begin
        if (!rates_differ || ext_sec_edge) begin
          // A jam landing on a frame tick in free-run mode takes the next frame so both stay in step
          gen_r <= (frame_tick_i && (mode_r == tc_holdoff_pkg::MODE_FREE)) ?
            tc_inc(ext_tc_i, drop_r) : ext_tc_i;
          xjam_pend_r <= 1'b0;
        end else begin
          xjam_pend_r <= 1'b1;
        end
      end else if (frame_tick_i) begin
        if (mode_r == tc_holdoff_pkg::MODE_OFF) begin
          gen_r <= gen_r;
        end else if (auto_mode && ar_r != tc_holdoff_pkg::AR_RECORD) begin
          gen_r <= gen_r;
        end else if ((mode_r != tc_holdoff_pkg::MODE_FREE) && ext_valid_i) begin
          gen_r <= ext_tc_i;
        end else begin
          gen_r <= tc_inc(gen_r, drop_r);
        end
      end
    end
  end

  // Sticky events: pending, record start, cancel; set wins over clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_r <= 3'h0;
    end else if (ce_i) begin
      irq_stat_r <= (irq_stat_r & ~((wr && paddr_i == tc_holdoff_pkg::APB_IRQ_CLR) ?
        pwdata_i[2:0] : 3'h0)) | {cancel_ev, rec_ev, pend_ev && auto_mode};
    end
  end

  // Read data
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0;
    end else if (ce_i && psel_i && !penable_i) begin
      case (paddr_i)
        tc_holdoff_pkg::APB_HOLDOFF: prdata_o <= {25'h0, holdoff_r};
        tc_holdoff_pkg::APB_MODE: prdata_o <= {19'h0, rate_r, 1'b0, ubmode_r, drop_r, mode_r};
        tc_holdoff_pkg::APB_PRESET: prdata_o <= {10'h0, preset_r};
        tc_holdoff_pkg::APB_STATUS: begin
          // Incoming rate above configured rate, as in the jam view
          prdata_o <= {11'h0, ext_rate_i, 3'h0, rate_r, 4'h0,
            no_editable_field_notice_o, !ext_valid_i, recording_o, record_pending_o};
        end
        tc_holdoff_pkg::APB_EXT: prdata_o <= {9'h0, !ext_valid_i, ext_tc_i};
        tc_holdoff_pkg::APB_GEN: prdata_o <= {10'h0, gen_r};
        tc_holdoff_pkg::APB_IRQ_STAT: prdata_o <= {29'h0, irq_stat_r};
        tc_holdoff_pkg::APB_IRQ_EN: prdata_o <= {29'h0, irq_en_r};
        default: prdata_o <= 32'h0;
      endcase
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign record_pending_o = (ar_r == tc_holdoff_pkg::AR_PENDING);
  assign recording_o = (ar_r == tc_holdoff_pkg::AR_RECORD);
  assign file_from_detect_o = preroll_set_i;
  assign ext_dashes_o = !ext_valid_i;
  assign gen_tc_o = gen_r;
  assign no_editable_field_notice_o = tc_holdoff_pkg::UB_NOEDIT_MASK[ubmode_r];
  assign irq_o = |(irq_stat_r & irq_en_r);

  AST_HOLDOFF_MAX: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    holdoff_r <= tc_holdoff_pkg::HOLDOFF_MAX) else $error("hold-off above limit");
  AST_REC_AFTER_PEND: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(recording_o) |-> $past(record_pending_o) && $past(expired))
    else $error("record without hold-off");
  AST_PEND_ONLY_AUTO: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(record_pending_o) |-> $past(auto_mode) && $past(ext_valid_i))
    else $error("pending outside auto mode");
  AST_CANCEL: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && record_pending_o && !ext_valid_i |=> !record_pending_o && !recording_o)
    else $error("pending not cancelled");
  AST_ZERO: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && jam_zero |=> gen_tc_o == '0) else $error("jam zero failed");
  AST_PRESET: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && jam_preset && !jam_zero |=> gen_tc_o == $past(preset_r))
    else $error("jam preset failed");
  AST_JAM_EXT: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && jam_ext && !jam_zero && !jam_preset && ext_valid_i && !rates_differ &&
    !frame_tick_i |=> gen_tc_o == $past(ext_tc_i)) else $error("jam external failed");
  AST_DROP: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && frame_tick_i && drop_r && (mode_r == tc_holdoff_pkg::MODE_FREE) && !cmd_wr &&
    !xjam_pend_r && (gen_r.frames == tc_holdoff_pkg::FRAME_MAX) &&
    (gen_r.seconds == tc_holdoff_pkg::MINSEC_MAX)
    |=> gen_tc_o.frames == (((gen_tc_o.minutes % 6'h0A) == 6'h00) ? 5'h00 : 5'h02))
    else $error("drop frame violated");
  AST_DASHES: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    ce_i && psel_i && !penable_i && (paddr_i == tc_holdoff_pkg::APB_EXT)
    |=> prdata_o[22] == $past(ext_dashes_o)) else $error("invalid flag mismatch");
endmodule
`default_nettype wire
